// ==== fpc_ctrl_model.sv ====
module fpc_ctrl_model (
    input wire logic hclk,
    input wire logic [4:0] code_a,
    input wire logic [4:0] code_b,
    input wire logic [7:0] dwell,
    output logic [9:0] pair_select_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // make before break on function a
    // dwell longer than the changeover time is how the bench provokes a fault
    logic [4:0] sel_a = 5'h01;
    logic [7:0] cnt = 8'h00;
    always @(posedge hclk) begin
        if (sel_a != code_a && cnt == 8'h00) begin
            sel_a <= sel_a | code_a;
            cnt <= dwell;
        end else if (cnt == 8'h01) begin
            sel_a <= code_a;
            cnt <= 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
    // function b presents each code in one step and holds it stable
    assign pair_select_in = {code_b, sel_a};
endmodule

// ==== fpc_interlock.sv ====
// What this block does
// - release request only for a button press lasting 0.12 s to 4 s
// - start interlock keeps outputs off after power-up until valid press
// - restart interlock keeps outputs off after violation until valid press
// - two protective functions A and B, ten field pairs each
// - changeover rule violation raises fault, forces that function's outputs off
// - modes per function: fixed, overlapped monitoring, fixed changeover moment
// - during changeover the previously active pair stays monitored
// - switch into occupied field: off after response time plus 40 ms
// - fixed mode monitors pair one and ignores select inputs
// - overlapped mode allowed only with at most five configured pairs
// - overlapped mode: a pair is active only while its input is high
// - overlapped: timer starts on second input; one input left at expiry
// - overlapped: function A decodes its five inputs one-hot, pairs one-five
// - function B decodes its own five inputs the same way
// - moment mode: controller gives stable valid code before time expires
// - moment mode: timer starts at first change on the five inputs
// - moment mode: new pair monitored only after changeover time expires
// - ten-pair code: one-hot pairs one-five, single low input pairs six-ten
// - inputs one-five steer function A, six-ten steer function B
// - order check on: forbidden changeover or disabled target turns outputs off
// - response time bounds violation-to-off delay
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
module fpc_interlock
    import fpc_pkg::*;
#(
    parameter int RES_MIN = RES_MIN_CYC,
    parameter int RES_MAX = RES_MAX_CYC,
    parameter int SYNC = SYNC_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [9:0] pair_select_in,
    input wire logic reset_button_in,
    input wire logic [1:0] field_occupied_in,
    output logic safe_output_pair_a,
    output logic safe_output_pair_b,
    output logic [1:0] fault_out,
    output logic [1:0] start_restart_lock,
    output logic [9:0] mon_pairs_a,
    output logic [9:0] mon_pairs_b
);
    // =========================================
    // input synchronisers
    logic [9:0] sel_s1_reg;
    logic [9:0] sel_reg;
    logic btn_s1_reg;
    logic btn_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_s1_reg <= '0;
            sel_reg <= '0;
            btn_s1_reg <= 1'b0;
            btn_reg <= 1'b0;
        end else begin
            sel_s1_reg <= pair_select_in;
            sel_reg <= sel_s1_reg;
            btn_s1_reg <= reset_button_in;
            btn_reg <= btn_s1_reg;
        end
    end

    // =========================================
    // AHB-Lite slave, zero wait states
    logic [31:0] ctrl_reg;
    logic [31:0] chg_time_reg;
    logic [31:0] resp_time_reg;
    logic [31:0] pair_en_reg;
    logic [9:0] order_reg [ORDER_WORDS];
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic hresp_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [7:0] ord_off;
    logic acc;

    logic safe_reg [2];
    logic fault_reg [2];
    logic lock_reg [2];
    logic trip_reg [2];
    logic run_reg [2];
    logic [3:0] cur_reg [2];
    logic [9:0] mask_reg [2];

    assign acc = hsel && htrans[1] && hready;
    assign ord_off = haddr[7:0] - ADDR_ORDER_BASE;
    assign status_word = {8'h00, cur_reg[1], cur_reg[0], 6'h00, run_reg[1], run_reg[0], trip_reg[1], trip_reg[0],
                          lock_reg[1], lock_reg[0], fault_reg[1], fault_reg[0], safe_reg[1], safe_reg[0]};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[7:0] == ADDR_CTRL) begin
            rd_mux = ctrl_reg;
        end else if (haddr[7:0] == ADDR_CHG_TIME) begin
            rd_mux = chg_time_reg;
        end else if (haddr[7:0] == ADDR_RESP_TIME) begin
            rd_mux = resp_time_reg;
        end else if (haddr[7:0] == ADDR_PAIR_EN) begin
            rd_mux = pair_en_reg;
        end else if (haddr[7:0] == ADDR_STATUS) begin
            rd_mux = status_word;
        end else if (haddr[7:0] >= ADDR_ORDER_BASE && haddr[7:0] <= ADDR_ORDER_LAST && haddr[1:0] == 2'h0) begin
            rd_mux = {22'h00_0000, order_reg[ord_off[6:2]]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            wr_pend_reg <= acc && hwrite;
            if (acc) begin
                wr_addr_reg <= haddr[7:0];
            end
            // read data is fetched in the address phase so it stands from a flop in the data phase
            if (acc && !hwrite) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RST;
            chg_time_reg <= CHG_TIME_RST;
            resp_time_reg <= RESP_TIME_RST;
            pair_en_reg <= PAIR_EN_RST;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == ADDR_CTRL) begin
                ctrl_reg <= {16'h0000, hwdata[15:8], 1'b0, hwdata[6:0]};
            end else if (wr_addr_reg == ADDR_CHG_TIME) begin
                chg_time_reg <= hwdata;
            end else if (wr_addr_reg == ADDR_RESP_TIME) begin
                resp_time_reg <= hwdata;
            end else if (wr_addr_reg == ADDR_PAIR_EN) begin
                pair_en_reg <= {12'h000, hwdata[19:0]};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < ORDER_WORDS; i++) begin
                order_reg[i] <= ORDER_RST;
            end
        end else begin
            for (int i = 0; i < ORDER_WORDS; i++) begin
                if (wr_pend_reg && wr_addr_reg == 8'(ADDR_ORDER_BASE + 4 * i)) begin
                    order_reg[i] <= hwdata[9:0];
                end
            end
        end
    end

    // =========================================
    // reset button press measurement
    logic btn_prev_reg;
    logic [27:0] press_cnt_reg;
    logic press_ok_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            btn_prev_reg <= 1'b0;
            press_cnt_reg <= 28'h000_0000;
            press_ok_reg <= 1'b0;
        end else begin
            btn_prev_reg <= btn_reg;
            // saturates one past the maximum so an overlong press stays invalid
            if (!btn_reg) begin
                press_cnt_reg <= 28'h000_0000;
            end else if (press_cnt_reg <= 28'(RES_MAX)) begin
                press_cnt_reg <= press_cnt_reg + 28'h000_0001;
            end
            press_ok_reg <= btn_prev_reg && !btn_reg && press_cnt_reg >= 28'(RES_MIN)
                            && press_cnt_reg <= 28'(RES_MAX);
        end
    end

    // =========================================
    // per protective function
    fpc_lock_t lock_mode;
    assign lock_mode = fpc_lock_t'(ctrl_reg[CTRL_LOCK_LSB+1:CTRL_LOCK_LSB]);

    for (genvar f = 0; f < 2; f++) begin : g_func
        logic [4:0] s;
        logic [4:0] prev_sel_reg;
        logic [31:0] cnt_reg;
        logic [31:0] viol_cnt_reg;
        logic [31:0] limit;
        logic sync_reg;
        fpc_mode_t mode;
        logic [3:0] pairs;
        logic [9:0] en;
        logic dec_ok;
        logic [3:0] dec_idx;
        logic [2:0] pc;
        logic expire;
        logic change;
        logic take;
        logic perm;
        logic fault_ev;
        logic occ;

        assign s = sel_reg[5*f+4:5*f];
        assign mode = fpc_mode_t'(ctrl_reg[CTRL_MODE_LSB+2*f+1:CTRL_MODE_LSB+2*f]);
        assign pairs = ctrl_reg[CTRL_COUNT_LSB+4*f+3:CTRL_COUNT_LSB+4*f];
        assign en = pair_en_reg[10*f+9:10*f];
        assign occ = field_occupied_in[f];
        assign pc = {2'h0, s[0]} + {2'h0, s[1]} + {2'h0, s[2]} + {2'h0, s[3]} + {2'h0, s[4]};
        assign expire = run_reg[f] && cnt_reg >= chg_time_reg;
        assign change = s != prev_sel_reg;

        always_comb begin
            dec_ok = 1'b1;
            dec_idx = 4'h0;
            case (s)
                5'h01: dec_idx = 4'h0;
                5'h02: dec_idx = 4'h1;
                5'h04: dec_idx = 4'h2;
                5'h08: dec_idx = 4'h3;
                5'h10: dec_idx = 4'h4;
                5'h0F: dec_idx = 4'h5;
                5'h17: dec_idx = 4'h6;
                5'h1B: dec_idx = 4'h7;
                5'h1D: dec_idx = 4'h8;
                5'h1E: dec_idx = 4'h9;
                default: dec_ok = 1'b0;
            endcase
            // single-low codes only exist in the ten-pair mode
            if (mode != MODE_MOMENT && pc != 3'h1) begin
                dec_ok = 1'b0;
            end
        end

        // disabled target or forbidden step only faults while the order check is on
        assign perm = !ctrl_reg[CTRL_ORDER_EN]
                      || (order_reg[5'(10 * f) + {1'b0, cur_reg[f]}][dec_idx] && en[dec_idx]);

        always_comb begin
            take = 1'b0;
            fault_ev = 1'b0;
            case (mode)
                MODE_FIXED: begin
                    take = 1'b0;
                end
                MODE_OVERLAP: begin
                    take = pc == 3'h1 && dec_idx != cur_reg[f];
                    fault_ev = pairs > 4'(OVERLAP_MAX_PAIRS)
                               || pc == 3'h0 || pc > 3'h2
                               || (pc == 3'h2 && expire);
                end
                MODE_MOMENT: begin
                    take = expire && dec_ok && dec_idx != cur_reg[f];
                    fault_ev = (expire || (!run_reg[f] && !change)) && !dec_ok;
                end
                default: begin
                    fault_ev = 1'b1;
                end
            endcase
            if (take && !perm) begin
                fault_ev = 1'b1;
            end
        end

        // changeover timer and monitored pair
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cur_reg[f] <= 4'h0;
                mask_reg[f] <= 10'h001;
                run_reg[f] <= 1'b0;
                cnt_reg <= 32'h0000_0000;
                prev_sel_reg <= 5'h00;
            end else begin
                prev_sel_reg <= s;
                if (mode == MODE_OVERLAP) begin
                    mask_reg[f] <= {5'h00, s};
                end else begin
                    mask_reg[f] <= 10'h001 << cur_reg[f];
                end
                if (mode == MODE_FIXED) begin
                    cur_reg[f] <= 4'h0;
                end else if (take && perm) begin
                    cur_reg[f] <= dec_idx;
                end
                if (mode == MODE_OVERLAP) begin
                    if (pc != 3'h2) begin
                        run_reg[f] <= 1'b0;
                    end else if (!run_reg[f]) begin
                        run_reg[f] <= 1'b1;
                        cnt_reg <= 32'h0000_0000;
                    end else if (!expire) begin
                        cnt_reg <= cnt_reg + 32'h0000_0001;
                    end
                end else if (mode == MODE_MOMENT) begin
                    if (run_reg[f]) begin
                        if (expire) begin
                            run_reg[f] <= 1'b0;
                        end else begin
                            cnt_reg <= cnt_reg + 32'h0000_0001;
                        end
                    end else if (change) begin
                        run_reg[f] <= 1'b1;
                        cnt_reg <= 32'h0000_0000;
                    end
                end else begin
                    run_reg[f] <= 1'b0;
                end
            end
        end

        // protective field violation timing
        assign limit = resp_time_reg + (sync_reg ? 32'(SYNC) : 32'h0000_0000);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sync_reg <= 1'b0;
                viol_cnt_reg <= 32'h0000_0000;
                trip_reg[f] <= 1'b0;
            end else begin
                if (take && perm) begin
                    sync_reg <= 1'b1;
                end else if (!occ) begin
                    sync_reg <= 1'b0;
                end
                if (!occ) begin
                    viol_cnt_reg <= 32'h0000_0000;
                    trip_reg[f] <= 1'b0;
                end else if (viol_cnt_reg >= limit) begin
                    trip_reg[f] <= 1'b1;
                end else begin
                    viol_cnt_reg <= viol_cnt_reg + 32'h0000_0001;
                end
            end
        end

        // interlock and fault; a new event beats a release in the same cycle
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lock_reg[f] <= 1'b1;
                fault_reg[f] <= 1'b0;
                safe_reg[f] <= 1'b0;
            end else begin
                if (lock_mode == LOCK_AUTO) begin
                    lock_reg[f] <= 1'b0;
                end else if (trip_reg[f] && lock_mode == LOCK_RESTART) begin
                    lock_reg[f] <= 1'b1;
                end else if (press_ok_reg && !occ) begin
                    lock_reg[f] <= 1'b0;
                end
                if (fault_ev) begin
                    fault_reg[f] <= 1'b1;
                end else if (press_ok_reg) begin
                    fault_reg[f] <= 1'b0;
                end
                safe_reg[f] <= !fault_reg[f] && !fault_ev && !lock_reg[f] && !trip_reg[f];
            end
        end
    end

    // =========================================
    // outputs
    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign safe_output_pair_a = safe_reg[0];
    assign safe_output_pair_b = safe_reg[1];
    assign fault_out = {fault_reg[1], fault_reg[0]};
    assign start_restart_lock = {lock_reg[1], lock_reg[0]};
    assign mon_pairs_a = mask_reg[0];
    assign mon_pairs_b = mask_reg[1];
endmodule

// ==== fpc_interlock_checker.sv ====
module fpc_interlock_checker
    import fpc_pkg::*;
#(
    parameter int RES_MIN = RES_MIN_CYC,
    parameter int RES_MAX = RES_MAX_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_button_in,
    input wire logic [1:0] field_occupied_in,
    input wire logic safe_output_pair_a,
    input wire logic safe_output_pair_b,
    input wire logic [1:0] fault_out,
    input wire logic [1:0] start_restart_lock,
    input wire logic [9:0] mon_pairs_a,
    input wire logic [9:0] mon_pairs_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // helper counters
    // bound assumes the bench sets a short response time before any occupancy
    localparam int RESP_BOUND = 35;
    int press_cnt;
    int occ_cnt;
    logic btn_q;
    logic bad_press;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            press_cnt <= 0;
            btn_q <= 1'b0;
        end else begin
            btn_q <= reset_button_in;
            press_cnt <= reset_button_in ? press_cnt + 1 : 0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            occ_cnt <= 0;
        end else begin
            occ_cnt <= field_occupied_in[0] ? occ_cnt + 1 : 0;
        end
    end
    // one cycle of slack each side: the design counts synchronised samples
    assign bad_press = btn_q && !reset_button_in && (press_cnt < RES_MIN - 1 || press_cnt > RES_MAX + 1);
    // =========================================
    // properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_reset_state;
        $rose(hresetn) |-> start_restart_lock == 2'b11 && !safe_output_pair_a && !safe_output_pair_b
            && fault_out == 2'b00 && mon_pairs_a == 10'h001;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("unsafe state at reset release");
    // safe output lags its cause by one edge, so only a settled lock is checked
    property p_lock_off_a;
        start_restart_lock[0] && $past(start_restart_lock[0]) |-> !safe_output_pair_a;
    endproperty
    a_lock_off_a: assert property (p_lock_off_a) else $error("output a on while locked");
    property p_lock_off_b;
        start_restart_lock[1] && $past(start_restart_lock[1]) |-> !safe_output_pair_b;
    endproperty
    a_lock_off_b: assert property (p_lock_off_b) else $error("output b on while locked");
    property p_fault_off_a;
        fault_out[0] |-> !safe_output_pair_a;
    endproperty
    a_fault_off_a: assert property (p_fault_off_a) else $error("output a on during fault");
    property p_fault_off_b;
        fault_out[1] |-> !safe_output_pair_b;
    endproperty
    a_fault_off_b: assert property (p_fault_off_b) else $error("output b on during fault");
    property p_mon_a;
        $countones(mon_pairs_a) inside {[1:2]};
    endproperty
    a_mon_a: assert property (p_mon_a) else $error("function a monitors no or too many pairs");
    property p_mon_b;
        $countones(mon_pairs_b) inside {[1:2]};
    endproperty
    a_mon_b: assert property (p_mon_b) else $error("function b monitors no or too many pairs");
    property p_short_press;
        bad_press |=> (!$fell(start_restart_lock[0]) && !$fell(start_restart_lock[1])) [*8];
    endproperty
    a_short_press: assert property (p_short_press) else $error("lock released by bad press");
    property p_resp_bound;
        occ_cnt >= RESP_BOUND |-> !safe_output_pair_a;
    endproperty
    a_resp_bound: assert property (p_resp_bound) else $error("output a on long after occupancy");
    c_release: cover property ($fell(start_restart_lock[0]));
    c_fault_b: cover property ($rose(fault_out[1]));
    c_overlap: cover property ($countones(mon_pairs_a) == 2);
endmodule

bind fpc_interlock fpc_interlock_checker #(
    .RES_MIN(RES_MIN),
    .RES_MAX(RES_MAX)
) u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .reset_button_in(reset_button_in),
    .field_occupied_in(field_occupied_in),
    .safe_output_pair_a(safe_output_pair_a),
    .safe_output_pair_b(safe_output_pair_b),
    .fault_out(fault_out),
    .start_restart_lock(start_restart_lock),
    .mon_pairs_a(mon_pairs_a),
    .mon_pairs_b(mon_pairs_b)
);

// ==== fpc_pkg.sv ====
package fpc_pkg;
    // =========================================
    // clock and timing
    localparam int CLK_MHZ = 50;
    localparam int RES_MIN_US = 120000;
    localparam int RES_MAX_US = 4000000;
    localparam int SYNC_MS = 40;
    // integer MHz clock, so these products are exact cycle counts
    localparam int RES_MIN_CYC = RES_MIN_US * CLK_MHZ;
    localparam int RES_MAX_CYC = RES_MAX_US * CLK_MHZ;
    localparam int SYNC_CYC = SYNC_MS * 1000 * CLK_MHZ;

    // =========================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHG_TIME = 8'h04;
    localparam logic [7:0] ADDR_RESP_TIME = 8'h08;
    localparam logic [7:0] ADDR_PAIR_EN = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_ORDER_BASE = 8'h40;
    localparam logic [7:0] ADDR_ORDER_LAST = 8'h8C;
    localparam int ORDER_WORDS = 20;

    // =========================================
    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LOCK_LSB = 4;
    localparam int CTRL_ORDER_EN = 6;
    localparam int CTRL_COUNT_LSB = 8;
    localparam int OVERLAP_MAX_PAIRS = 5;

    // =========================================
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_5520;
    localparam logic [31:0] CHG_TIME_RST = 32'h004C_4B40;
    localparam logic [31:0] RESP_TIME_RST = 32'h003D_0900;
    localparam logic [31:0] PAIR_EN_RST = 32'h000F_FFFF;
    localparam logic [9:0] ORDER_RST = 10'h3FF;

    // =========================================
    // modes
    typedef enum logic [1:0] {
        MODE_FIXED,
        MODE_OVERLAP,
        MODE_MOMENT,
        MODE_RSVD
    } fpc_mode_t;

    typedef enum logic [1:0] {
        LOCK_AUTO,
        LOCK_START,
        LOCK_RESTART,
        LOCK_RSVD
    } fpc_lock_t;
endpackage

// ==== tb_top.sv ====
module tb_top
    import fpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic btn = 1'b0;
    logic [1:0] occ = 2'h0;
    logic [4:0] code_a = 5'h01;
    logic [4:0] code_b = 5'h01;
    logic [7:0] dwell = 8'h0A;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [9:0] sel;
    logic safe_a;
    logic safe_b;
    logic [1:0] fault;
    logic [1:0] lock;
    logic [9:0] mon_a;
    logic [9:0] mon_b;
    int n_mismatch = 0;
    int compares = 0;
    always #10 hclk = ~hclk;
    fpc_ctrl_model u_ctrl (.hclk(hclk), .code_a(code_a), .code_b(code_b), .dwell(dwell), .pair_select_in(sel));
    // short press window and sync so the run stays brief
    fpc_interlock #(.RES_MIN(6), .RES_MAX(40), .SYNC(10)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pair_select_in(sel), .reset_button_in(btn), .field_occupied_in(occ),
        .safe_output_pair_a(safe_a), .safe_output_pair_b(safe_b), .fault_out(fault),
        .start_restart_lock(lock), .mon_pairs_a(mon_a), .mon_pairs_b(mon_b));
    // =========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        chk(32'(hresp), 32'h0);
        if (!w) chk(hrdata, exp);
    endtask
    task automatic press(input int n);
        btn <= 1'b1;
        repeat (n) @(posedge hclk);
        btn <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
    function automatic logic [4:0] code_of(input int i);
        return (i < 5) ? 5'(5'h01 << i) : 5'(~(5'h10 >> (i - 5)));
    endfunction
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // =========================================
    // tests
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'(lock), 32'h3);
        chk(32'({safe_b, safe_a}), 32'h0);
        bus(1'b0, ADDR_CTRL, 32'h0, CTRL_RST);
        bus(1'b0, ADDR_PAIR_EN, 32'h0, PAIR_EN_RST);
        bus(1'b0, 8'h20, 32'h0, 32'h0);
        bus(1'b1, ADDR_RESP_TIME, 32'h14, 32'h0);
        bus(1'b1, ADDR_CHG_TIME, 32'h10, 32'h0);
        bus(1'b0, ADDR_CHG_TIME, 32'h0, 32'h10);
        code_a <= 5'h02;
        press(3);
        chk(32'(lock), 32'h3);
        press(60);
        chk(32'(lock), 32'h3);
        press(10);
        chk(32'(lock), 32'h0);
        chk(32'({safe_b, safe_a}), 32'h3);
        chk(32'(mon_a), 32'h1);
        occ <= 2'b01;
        repeat (40) @(posedge hclk);
        chk(32'({safe_b, safe_a}), 32'h2);
        occ <= 2'b00;
        repeat (5) @(posedge hclk);
        chk(32'({safe_b, safe_a}), 32'h2);
        press(10);
        chk(32'({safe_b, safe_a}), 32'h3);
        code_a <= 5'h01;
        repeat (15) @(posedge hclk);
        bus(1'b1, ADDR_CTRL, 32'h0000_5521, 32'h0);
        repeat (5) @(posedge hclk);
        code_a <= 5'h04;
        repeat (7) @(posedge hclk);
        chk(32'(mon_a), 32'h5);
        repeat (20) @(posedge hclk);
        chk(32'(mon_a), 32'h4);
        chk(32'(fault), 32'h0);
        dwell <= 8'h28;
        code_a <= 5'h01;
        repeat (30) @(posedge hclk);
        chk(32'({fault, safe_a}), 32'h2);
        repeat (30) @(posedge hclk);
        press(10);
        chk(32'(fault), 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0000_5529, 32'h0);
        repeat (5) @(posedge hclk);
        for (int i = 1; i < 10; i++) begin
            code_b <= code_of(i);
            repeat (6) @(posedge hclk);
            chk(32'(mon_b), 32'(10'h001 << (i - 1)));
            repeat (30) @(posedge hclk);
            chk(32'(mon_b), 32'(10'h001 << i));
        end
        chk(32'(fault), 32'h0);
        code_b <= 5'h03;
        repeat (40) @(posedge hclk);
        chk(32'({fault, safe_b, safe_a}), 32'h9);
        code_b <= 5'h02;
        repeat (40) @(posedge hclk);
        press(10);
        chk(32'(fault), 32'h0);
        bus(1'b1, ADDR_PAIR_EN, 32'h000F_FBFF, 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0000_5569, 32'h0);
        code_b <= 5'h01;
        repeat (40) @(posedge hclk);
        chk(32'(fault), 32'h2);
        // six configured pairs make overlapped mode illegal for function a
        bus(1'b1, ADDR_CTRL, 32'h0000_5669, 32'h0);
        repeat (5) @(posedge hclk);
        chk(32'(fault), 32'h3);
        // start interlock only: a trip must not latch the lock
        bus(1'b1, ADDR_CTRL, 32'h0000_5510, 32'h0);
        press(10);
        chk(32'(fault), 32'h0);
        occ <= 2'b01;
        repeat (30) @(posedge hclk);
        chk(32'({safe_b, safe_a}), 32'h2);
        occ <= 2'b00;
        repeat (5) @(posedge hclk);
        chk(32'({lock, safe_b, safe_a}), 32'h3);
        test_done;
    end
endmodule
